/* shared/move_ret_pkg.sv */
// Shared constants, encodings and register map of the execution core
`default_nettype none
package move_ret_pkg;
  // ***************************************************
  // Widths
  // ***************************************************
  localparam int ADDR_W      = 7;
  localparam int DATA_W      = 8;
  localparam int PC_W        = 13;
  localparam int INSTR_W     = 14;
  localparam int STACK_DEPTH = 8;
  localparam int STACK_PTR_W = 3;
  localparam int APB_ADDR_W  = 8;
  localparam int APB_DATA_W  = 32;

  // ***************************************************
  // Instruction encodings (mask and match)
  // ***************************************************
  localparam logic [13:0] FILE_OP_MASK   = 14'h3F00;
  localparam logic [13:0] OR_FILE_MATCH  = 14'h0400;
  localparam logic [13:0] COPY_MATCH     = 14'h0800;
  localparam logic [13:0] STORE_MASK     = 14'h3F80;
  localparam logic [13:0] STORE_MATCH    = 14'h0080;
  localparam logic [13:0] LOAD_MASK      = 14'h3C00;
  localparam logic [13:0] LOAD_MATCH     = 14'h3000;
  localparam logic [13:0] IDLE_MASK      = 14'h3F9F;
  localparam logic [13:0] IDLE_MATCH     = 14'h0000;
  localparam logic [13:0] IRQ_RET_MATCH  = 14'h0009;
  localparam int          DEST_BIT       = 7;

  // ***************************************************
  // Register map (byte offsets) and field positions
  // ***************************************************
  localparam logic [7:0] CTRL_OFS    = 8'h00;
  localparam logic [7:0] ACCUM_OFS   = 8'h04;
  localparam logic [7:0] STATUS_OFS  = 8'h08;
  localparam logic [7:0] IRQCTL_OFS  = 8'h0C;
  localparam logic [7:0] PC_OFS      = 8'h10;
  localparam logic [7:0] RETIRED_OFS = 8'h14;
  localparam int RUN_BIT    = 0;
  localparam int ZERO_BIT   = 2;
  localparam int UNSUP_BIT  = 8;
  localparam int GLOBAL_IRQ_BIT = 7;

  // ***************************************************
  // Reset values
  // ***************************************************
  localparam logic              RUN_RST   = 1'b1;
  localparam logic [DATA_W-1:0] ACCUM_RST = 8'h00;
  localparam logic [PC_W-1:0]   PC_RST    = 13'h0000;
  localparam logic              IRQ_EN_RST = 1'b0;
  localparam logic              ZERO_RST  = 1'b0;

  // ***************************************************
  // Sequencer states; two clocks make one instruction cycle
  // ***************************************************
  typedef enum logic [3:0] {
    ST_FETCH = 4'b0001,
    ST_EXEC  = 4'b0010,
    ST_DRAIN = 4'b0100,
    ST_DRAIN2 = 4'b1000
  } exec_state_e;
endpackage
`default_nettype wire

/* design/file_ram.sv */
// File register memory, 128 bytes, registered read data
`timescale 1ns/1ps
`default_nettype none
module file_ram
  import move_ret_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              wrEn,
  input  wire logic [ADDR_W-1:0] wrAddr,
  input  wire logic [DATA_W-1:0] wrData,
  input  wire logic [ADDR_W-1:0] rdAddr,
  output logic      [DATA_W-1:0] rdData
);
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

  // Read before write; a read of the same cell sees the old byte
  always_ff @(posedge core_clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
    rdData <= mem[rdAddr];
  end
endmodule
`default_nettype wire

/* design/return_stack.sv */
// Eight-level circular hardware return stack
`timescale 1ns/1ps
`default_nettype none
module return_stack
  import move_ret_pkg::*;
(
  input  wire logic            core_clk,
  input  wire logic            reset,
  input  wire logic            pushEn,
  input  wire logic [PC_W-1:0] pushData,
  input  wire logic            popEn,
  output logic      [PC_W-1:0] topData
);
  logic [STACK_PTR_W-1:0] ptr_q;
  logic [STACK_PTR_W-1:0] topIdx;
  logic [PC_W-1:0]        entry_q [0:STACK_DEPTH-1];

  // Pointer names the next free slot; it wraps, no overflow flag
  assign topIdx  = ptr_q - 3'd1;
  assign topData = entry_q[topIdx];

  // Push with pop in one cycle replaces the top in place
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ptr_q <= '0;
    end else if (pushEn && !popEn) begin
      ptr_q <= ptr_q + 3'd1;
    end else if (popEn && !pushEn) begin
      ptr_q <= topIdx;
    end
  end

  // One register per slot
  for (genvar i = 0; i < STACK_DEPTH; i++) begin : gSlot
    always_ff @(posedge core_clk) begin
      if (pushEn && popEn && topIdx == STACK_PTR_W'(i)) begin
        entry_q[i] <= pushData;
      end else if (pushEn && !popEn && ptr_q == STACK_PTR_W'(i)) begin
        entry_q[i] <= pushData;
      end
    end
  end
endmodule
`default_nettype wire

/* design/move_or_return_instr_exec.sv */
// Execution core for OR, copy, store, load, idle and interrupt return
// Functional notes
// - OR accumulator with file register; destination bit picks accumulator or file
// - OR and copy-from-file results update the zero flag
// - Copy file register to accumulator or back to itself, one word, one cycle
// - Store accumulator into file register, flags untouched, one cycle
// - Load 8-bit immediate into accumulator, flags untouched, one cycle
// - Interrupt return pops the stack into the program counter
// - Interrupt return sets global interrupt enable, bit 7 of irq control
// - Interrupt return takes two instruction cycles, one word, flags untouched
//
// The placing of the registers and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module move_or_return_instr_exec
  import move_ret_pkg::*;
(
  input  wire logic                  core_clk,
  input  wire logic                  reset,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [APB_ADDR_W-1:0] paddr,
  input  wire logic [APB_DATA_W-1:0] pwdata,
  output logic      [APB_DATA_W-1:0] prdata,
  output logic                       pready,
  output logic                       pslverr,
  output logic      [PC_W-1:0]       progAddr,
  input  wire logic [INSTR_W-1:0]    instrWord,
  input  wire logic                  pushValid,
  input  wire logic [PC_W-1:0]       pushAddr,
  output logic                       irqEnable,
  output logic                       retireStrobe
);
  // ***************************************************
  // State
  // ***************************************************
  exec_state_e            state_q;
  exec_state_e            state_d;
  logic [INSTR_W-1:0]     instr_q;
  logic [DATA_W-1:0]      accum_q;
  logic [DATA_W-1:0]      accum_d;
  logic [PC_W-1:0]        pc_q;
  logic [PC_W-1:0]        pc_d;
  logic                   zero_q;
  logic                   zero_d;
  logic                   irqEn_q;
  logic                   irqEn_d;
  logic                   unsup_q;
  logic                   unsup_d;
  logic                   run_q;
  logic [APB_DATA_W-1:0]  retired_q;
  logic [APB_DATA_W-1:0]  prdata_q;
  logic                   retire_q;

  // ***************************************************
  // Decode of the latched instruction word
  // ***************************************************
  logic              isOrFile;
  logic              isCopy;
  logic              isStore;
  logic              isLoad;
  logic              isIdle;
  logic              isIrqRet;
  logic              isKnown;
  logic              destFile;
  logic [ADDR_W-1:0] fileAddr;
  logic [DATA_W-1:0] immediate;

  // Fixed-field compares; unused literal bits are ignored
  assign isOrFile  = (instr_q & FILE_OP_MASK) == OR_FILE_MATCH;
  assign isCopy    = (instr_q & FILE_OP_MASK) == COPY_MATCH;
  assign isStore   = (instr_q & STORE_MASK) == STORE_MATCH;
  assign isLoad    = (instr_q & LOAD_MASK) == LOAD_MATCH;
  assign isIrqRet  = instr_q == IRQ_RET_MATCH;
  assign isIdle    = ((instr_q & IDLE_MASK) == IDLE_MATCH) && !isIrqRet;
  assign isKnown   = isOrFile | isCopy | isStore | isLoad | isIdle | isIrqRet;
  assign destFile  = instr_q[DEST_BIT];
  assign fileAddr  = instr_q[ADDR_W-1:0];
  assign immediate = instr_q[DATA_W-1:0];

  // ***************************************************
  // Sequencer phases
  // ***************************************************
  logic fetchStep;
  logic execStep;
  logic drainEnd;

  // Fetch only moves on while software lets the core run
  assign fetchStep = (state_q == ST_FETCH) && run_q;
  assign execStep  = state_q == ST_EXEC;
  assign drainEnd  = state_q == ST_DRAIN2;

  // Next phase; return adds a second, empty instruction cycle
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_FETCH: begin
        if (run_q) begin
          state_d = ST_EXEC;
        end
      end
      ST_EXEC: begin
        if (isIrqRet) begin
          state_d = ST_DRAIN;
        end else begin
          state_d = ST_FETCH;
        end
      end
      ST_DRAIN: begin
        state_d = ST_DRAIN2;
      end
      ST_DRAIN2: begin
        state_d = ST_FETCH;
      end
      default: begin
        state_d = ST_FETCH;
      end
    endcase
  end

  // Sequencer register
  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_q <= ST_FETCH;
    end else begin
      state_q <= state_d;
    end
  end

  // Instruction word latched at the end of fetch
  always_ff @(posedge core_clk) begin
    if (reset) begin
      instr_q <= IDLE_MATCH;
    end else if (fetchStep) begin
      instr_q <= instrWord;
    end
  end

  // ***************************************************
  // File register memory and data path
  // ***************************************************
  logic [DATA_W-1:0] fileRd;
  logic [DATA_W-1:0] orResult;
  logic [DATA_W-1:0] flagResult;
  logic              fileWrEn;
  logic [DATA_W-1:0] fileWrData;

  // Read is issued straight from the fetched word so data is ready in exec
  file_ram uRam (
    .core_clk (core_clk),
    .wrEn     (fileWrEn),
    .wrAddr   (fileAddr),
    .wrData   (fileWrData),
    .rdAddr   (instrWord[ADDR_W-1:0]),
    .rdData   (fileRd)
  );

  assign orResult   = accum_q | fileRd;
  assign flagResult = isOrFile ? orResult : fileRd;

  // File write: OR or copy with destination set, or store
  assign fileWrEn = execStep &&
                    (((isOrFile || isCopy) && destFile) || isStore);
  assign fileWrData = isStore ? accum_q : flagResult;

  // ***************************************************
  // Return stack
  // ***************************************************
  logic            popEn;
  logic [PC_W-1:0] stackTop;

  assign popEn = execStep && isIrqRet;

  return_stack uStack (
    .core_clk (core_clk),
    .reset    (reset),
    .pushEn   (pushValid),
    .pushData (pushAddr),
    .popEn    (popEn),
    .topData  (stackTop)
  );

  // ***************************************************
  // APB slave, zero wait states
  // ***************************************************
  logic                  apbSetup;
  logic                  apbWrite;
  logic                  hitCtrl;
  logic                  hitAccum;
  logic                  hitStatus;
  logic                  hitIrq;
  logic                  hitPc;
  logic                  hitRetired;
  logic                  addrHit;
  logic [APB_DATA_W-1:0] readMux;

  assign apbSetup   = psel && !penable;
  assign apbWrite   = psel && penable && pwrite;
  assign hitCtrl    = paddr == CTRL_OFS;
  assign hitAccum   = paddr == ACCUM_OFS;
  assign hitStatus  = paddr == STATUS_OFS;
  assign hitIrq     = paddr == IRQCTL_OFS;
  assign hitPc      = paddr == PC_OFS;
  assign hitRetired = paddr == RETIRED_OFS;
  assign addrHit    = hitCtrl | hitAccum | hitStatus | hitIrq | hitPc | hitRetired;

  // Read selection; reserved bits read as zero
  assign readMux =
      hitCtrl    ? {31'h0, run_q} :
      hitAccum   ? {24'h0, accum_q} :
      hitStatus  ? {23'h0, unsup_q, 5'h0, zero_q, 2'h0} :
      hitIrq     ? {24'h0, irqEn_q, 7'h0} :
      hitPc      ? {19'h0, pc_q} :
      hitRetired ? retired_q : 32'h0;

  // Read data is captured in setup so it is stable through access
  always_ff @(posedge core_clk) begin
    if (reset) begin
      prdata_q <= 32'h0;
    end else if (apbSetup) begin
      prdata_q <= readMux;
    end
  end

  assign prdata  = prdata_q;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !addrHit;

  // Run enable is the only control bit
  always_ff @(posedge core_clk) begin
    if (reset) begin
      run_q <= RUN_RST;
    end else if (apbWrite && hitCtrl) begin
      run_q <= pwdata[RUN_BIT];
    end
  end

  // ***************************************************
  // Accumulator and flags
  // ***************************************************
  // Core update beats a software write in the same cycle
  always_comb begin
    accum_d = accum_q;
    if (execStep && (isOrFile || isCopy) && !destFile) begin
      accum_d = flagResult;
    end else if (execStep && isLoad) begin
      accum_d = immediate;
    end else if (apbWrite && hitAccum) begin
      accum_d = pwdata[DATA_W-1:0];
    end
  end

  // Store, load, idle and return leave zero alone
  always_comb begin
    zero_d = zero_q;
    if (execStep && (isOrFile || isCopy)) begin
      zero_d = flagResult == 8'h00;
    end else if (apbWrite && hitStatus) begin
      zero_d = pwdata[ZERO_BIT];
    end
  end

  // Unknown words act as idle and leave a sticky mark; write 1 clears
  always_comb begin
    unsup_d = unsup_q;
    if (apbWrite && hitStatus && pwdata[UNSUP_BIT]) begin
      unsup_d = 1'b0;
    end
    if (execStep && !isKnown) begin
      unsup_d = 1'b1;
    end
  end

  // Hardware set wins over software clear in the same cycle
  always_comb begin
    irqEn_d = irqEn_q;
    if (apbWrite && hitIrq) begin
      irqEn_d = pwdata[GLOBAL_IRQ_BIT];
    end
    if (popEn) begin
      irqEn_d = 1'b1;
    end
  end

  // Program counter: pop on return, else step by one word
  always_comb begin
    pc_d = pc_q;
    if (popEn) begin
      pc_d = stackTop;
    end else if (execStep) begin
      pc_d = pc_q + 13'd1;
    end
  end

  // Architectural registers
  always_ff @(posedge core_clk) begin
    if (reset) begin
      accum_q <= ACCUM_RST;
      zero_q  <= ZERO_RST;
      unsup_q <= 1'b0;
      irqEn_q <= IRQ_EN_RST;
      pc_q    <= PC_RST;
    end else begin
      accum_q <= accum_d;
      zero_q  <= zero_d;
      unsup_q <= unsup_d;
      irqEn_q <= irqEn_d;
      pc_q    <= pc_d;
    end
  end

  // ***************************************************
  // Retirement
  // ***************************************************
  logic retireNow;

  // Return retires only after its empty second cycle
  assign retireNow = (execStep && !isIrqRet) || drainEnd;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      retired_q <= 32'h0;
      retire_q  <= 1'b0;
    end else begin
      retire_q <= retireNow;
      if (retireNow) begin
        retired_q <= retired_q + 32'h1;
      end
    end
  end

  // ***************************************************
  // Outputs
  // ***************************************************
  assign progAddr     = pc_q;
  assign irqEnable    = irqEn_q;
  assign retireStrobe = retire_q;
endmodule
`default_nettype wire

/* sim/prog_mem_model.sv */
// Behavioural program memory feeding instruction words to the core
`timescale 1ns/1ps
`default_nettype none
module prog_mem_model
  import move_ret_pkg::*;
(
  input  wire logic [PC_W-1:0]    progAddr,
  output logic      [INSTR_W-1:0] instrWord
);
  logic [INSTR_W-1:0] mem [0:(1<<PC_W)-1];

  // Blank words read as the idle encoding, so gaps act as idle padding
  initial begin
    for (int i = 0; i < (1<<PC_W); i++) begin
      mem[i] = 14'h0000;
    end
  end

  // Combinational word, valid within the fetch clock
  assign instrWord = mem[progAddr];
endmodule
`default_nettype wire

/* sim/move_or_return_instr_exec_assertions.sv */
// Concurrent checks on the execution core ports
`timescale 1ns/1ps
`default_nettype none
module move_or_return_instr_exec_assertions
  import move_ret_pkg::*;
(
  input wire logic                  core_clk,
  input wire logic                  reset,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [APB_ADDR_W-1:0] paddr,
  input wire logic [APB_DATA_W-1:0] pwdata,
  input wire logic [APB_DATA_W-1:0] prdata,
  input wire logic                  pready,
  input wire logic                  pslverr,
  input wire logic [PC_W-1:0]       progAddr,
  input wire logic [INSTR_W-1:0]    instrWord,
  input wire logic                  pushValid,
  input wire logic [PC_W-1:0]       pushAddr,
  input wire logic                  irqEnable,
  input wire logic                  retireStrobe
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  // Run bit as last written over the bus; a stalled fetch must not count as a start
  logic runShadow_q;

  // Decode of the word fetched in a cycle that follows a retire
  wire logic isOne    = ((instrWord & FILE_OP_MASK) == OR_FILE_MATCH)
                     || ((instrWord & FILE_OP_MASK) == COPY_MATCH)
                     || ((instrWord & STORE_MASK) == STORE_MATCH)
                     || ((instrWord & LOAD_MASK) == LOAD_MATCH)
                     || ((instrWord & IDLE_MASK) == IDLE_MATCH);
  wire logic retFetch = retireStrobe && (instrWord == IRQ_RET_MATCH) && runShadow_q;
  wire logic oneFetch = retireStrobe && isOne && runShadow_q;
  wire logic access   = psel && penable;

  // Shadow of the run bit, updated at the edge where the bus write lands
  always_ff @(posedge core_clk) begin
    if (reset) begin
      runShadow_q <= RUN_RST;
    end else if (access && pwrite && (paddr == CTRL_OFS)) begin
      runShadow_q <= pwdata[RUN_BIT];
    end
  end
  wire logic unmapped = (paddr > RETIRED_OFS) || (paddr[1:0] != 2'b00);

  // Return occupies three quiet clocks before its retire pulse
  sequence s_drain;
    !retireStrobe [*3];
  endsequence
  sequence s_single;
    !retireStrobe ##1 retireStrobe;
  endsequence

  property p_ret_len;  retFetch |-> ##1 s_drain ##1 retireStrobe; endproperty
  property p_ret_irq;  retFetch |-> ##2 irqEnable; endproperty
  property p_one_len;  oneFetch |-> ##1 s_single; endproperty
  property p_one_pc;   oneFetch |-> ##2 (progAddr == $past(progAddr, 2) + 13'h0001); endproperty
  property p_pc_move;  !$stable(progAddr) |-> retireStrobe || $past(retFetch, 2); endproperty
  property p_pready;   access |-> pready; endproperty
  property p_slverr;   pslverr == (access && unmapped); endproperty
  // Enable only rises from a return or a software write of bit 7
  property p_irq_rise;
    $rose(irqEnable) |-> $past(retFetch, 2)
      || $past(access && pwrite && (paddr == IRQCTL_OFS) && pwdata[GLOBAL_IRQ_BIT]);
  endproperty

  a_ret_len:  assert property (p_ret_len)  else $error("return length wrong");
  a_ret_irq:  assert property (p_ret_irq)  else $error("irq enable not set");
  a_one_len:  assert property (p_one_len)  else $error("single cycle wrong");
  a_one_pc:   assert property (p_one_pc)   else $error("pc not advanced");
  a_pc_move:  assert property (p_pc_move)  else $error("pc moved unexpectedly");
  a_pready:   assert property (p_pready)   else $error("pready low");
  a_slverr:   assert property (p_slverr)   else $error("pslverr wrong");
  a_irq_rise: assert property (p_irq_rise) else $error("irq enable rose alone");
endmodule

bind move_or_return_instr_exec move_or_return_instr_exec_assertions chk (
  .core_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
  .pslverr, .progAddr, .instrWord, .pushValid, .pushAddr, .irqEnable, .retireStrobe
);
`default_nettype wire

/* sim/testbench.sv */
// Self-checking bench running small programs and reading results over APB
`timescale 1ns/1ps
`default_nettype none
module testbench
  import move_ret_pkg::*;
;
  logic core_clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, stopRet;
  logic pready, pslverr, err, irqEnable, retireStrobe, pushValid = 1'b0;
  logic [PC_W-1:0] progAddr, pushAddr = 13'h0000, stopPc;
  logic [INSTR_W-1:0] instrWord;
  int bad_count = 0, check_count = 0, n;

  always #12.5 core_clk = ~core_clk;

  move_or_return_instr_exec dut (.core_clk(core_clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .progAddr(progAddr), .instrWord(instrWord),
    .pushValid(pushValid), .pushAddr(pushAddr), .irqEnable(irqEnable),
    .retireStrobe(retireStrobe));
  prog_mem_model pm (.progAddr(progAddr), .instrWord(instrWord));

  // ***************************************************
  // Helpers
  // ***************************************************
  function automatic logic [13:0] fop(logic [13:0] m, logic d, logic [6:0] f);
    return m | {6'h00, d, f};
  endfunction

  task finish_test;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // One APB transfer; request held until pready is seen at an edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int i;
    @(posedge core_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge core_clk);
      if (pready === 1'b1) break;
    end
    if (i == 50) begin chk(0, 1, "apb timeout"); finish_test(); end
    rd = prdata; err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task regChk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
    apb(1'b0, a, 32'h0);
    chk(rd & m, exp, "register");
  endtask

  // Counts clocks until the core fetches at address a; sampled mid-cycle
  task waitPc(input logic [PC_W-1:0] a);
    for (n = 0; n < 3000 && progAddr !== a; n++) @(negedge core_clk);
    if (n == 3000) begin chk(0, 1, "pc timeout"); finish_test(); end
  endtask

  // ***************************************************
  // Main sequence
  // ***************************************************
  initial begin
    #1;
    pm.mem[0]   = LOAD_MATCH | 14'h005A;
    pm.mem[1]   = fop(STORE_MATCH, 1'b1, 7'h7F);
    pm.mem[2]   = LOAD_MATCH | 14'h0081;
    pm.mem[3]   = fop(OR_FILE_MATCH, 1'b0, 7'h7F);
    pm.mem[32]  = LOAD_MATCH;
    pm.mem[33]  = fop(STORE_MATCH, 1'b1, 7'h11);
    pm.mem[34]  = fop(OR_FILE_MATCH, 1'b0, 7'h11);
    pm.mem[35]  = LOAD_MATCH | 14'h0077;
    pm.mem[64]  = fop(OR_FILE_MATCH, 1'b1, 7'h7F);
    pm.mem[65]  = fop(COPY_MATCH, 1'b0, 7'h7F);
    pm.mem[96]  = LOAD_MATCH;
    pm.mem[97]  = fop(STORE_MATCH, 1'b1, 7'h12);
    pm.mem[98]  = LOAD_MATCH | 14'h0099;
    pm.mem[99]  = fop(COPY_MATCH, 1'b1, 7'h12);
    pm.mem[100] = fop(STORE_MATCH, 1'b1, 7'h13); // Nonzero store must keep zero set
    pm.mem[128] = IRQ_RET_MATCH;
    pm.mem[13'h0F10] = 14'h3FFF; // Unknown word, acts as idle
    repeat (4) @(posedge core_clk);
    reset <= 1'b0;
    waitPc(13'd8);
    regChk(ACCUM_OFS, 32'hDB, 32'hFF);
    regChk(STATUS_OFS, 32'h0, 32'h4);
    $display("test or_into_accum done");
    waitPc(13'd40);
    regChk(ACCUM_OFS, 32'h77, 32'hFF);
    regChk(STATUS_OFS, 32'h4, 32'h4);
    $display("test zero_and_load done");
    waitPc(13'd72);
    regChk(ACCUM_OFS, 32'h7F, 32'hFF);
    regChk(STATUS_OFS, 32'h0, 32'h4);
    $display("test or_into_file done");
    waitPc(13'd104);
    regChk(ACCUM_OFS, 32'h99, 32'hFF);
    regChk(STATUS_OFS, 32'h4, 32'h4);
    $display("test copy_back done");
    // Return address pushed while the core idles
    @(posedge core_clk);
    pushValid <= 1'b1; pushAddr <= 13'h0F00;
    @(posedge core_clk);
    pushValid <= 1'b0;
    chk({31'h0, irqEnable}, 32'h0, "irq before");
    waitPc(13'd128);
    waitPc(13'h0F00);
    chk(n, 2, "pop delay");
    chk({31'h0, irqEnable}, 32'h1, "irq after");
    waitPc(13'h0F01);
    chk(n, 4, "return length");
    waitPc(13'h0F02);
    chk(n, 2, "idle length");
    regChk(ACCUM_OFS, 32'h99, 32'hFF);
    regChk(STATUS_OFS, 32'h4, 32'h4);
    $display("test interrupt_return done");
    apb(1'b0, 8'h18, 32'h0);
    chk(rd, 32'h0, "unmapped data");
    chk({31'h0, err}, 32'h1, "unmapped error");
    $display("test unmapped done");
    // Sticky unknown mark, register writes, then run control stall and resume
    waitPc(13'h0F11);
    regChk(STATUS_OFS, 32'h104, 32'h104);
    apb(1'b1, STATUS_OFS, 32'h104);
    regChk(STATUS_OFS, 32'h4, 32'h104);
    apb(1'b1, IRQCTL_OFS, 32'h0);
    regChk(IRQCTL_OFS, 32'h0, 32'h80);
    chk({31'h0, irqEnable}, 32'h0, "irq cleared");
    apb(1'b1, ACCUM_OFS, 32'h3C);
    regChk(ACCUM_OFS, 32'h3C, 32'hFF);
    apb(1'b1, CTRL_OFS, 32'h0);
    regChk(CTRL_OFS, 32'h0, 32'h1);
    apb(1'b0, PC_OFS, 32'h0);
    stopPc = rd[PC_W-1:0];
    apb(1'b0, RETIRED_OFS, 32'h0);
    stopRet = rd;
    repeat (8) @(posedge core_clk);
    regChk(PC_OFS, {19'h0, stopPc}, 32'h1FFF);
    chk({19'h0, progAddr}, {19'h0, stopPc}, "stalled pc");
    apb(1'b1, CTRL_OFS, 32'h1);
    waitPc(stopPc + 13'd1);
    regChk(RETIRED_OFS, stopRet + 32'h1, 32'hFFFFFFFF);
    $display("test software_access done");
    finish_test();
  end
endmodule
`default_nettype wire
